// ---- bench/pmx_periph_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// peripheral side: registered override sources and a resynchroniser
module pmx_periph_model import pmx_pkg::*; #(
  parameter int N = 6
) (
  // clock
  input wire logic aclk,
  // wanted overrides, index 0..8 as on the port list
  input wire logic [8:0][N-1:0] want,
  output var logic [8:0][N-1:0] ovr,
  // alternate input and its synchronised copy
  input wire logic [N-1:0] alt_in,
  output var logic [N-1:0] alt_sync
);
  logic [8:0][N-1:0] ovr_next;
  logic [N-1:0] meta_reg, meta_next, sync_next;
  // no reset gating: a peripheral may assert overrides while the port is in reset
  always_comb begin
    ovr_next = want;
    meta_next = alt_in;
    sync_next = meta_reg;
  end
  // register only
  always_ff @(posedge aclk) begin
    ovr <= ovr_next;
    meta_reg <= meta_next;
    alt_sync <= sync_next;
  end
endmodule : pmx_periph_model
`default_nettype wire

// ---- bench/pmx_port_checker_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port-level checks on the pad mux
module pmx_port_checker import pmx_pkg::*; #(
  parameter int N = 6,
  parameter logic [N-1:0] ALT_MASK = '1,
  parameter int EXT_INT_PIN = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sleep and overrides
  input wire logic power_down,
  input wire logic [N-1:0] pullup_override_en,
  input wire logic [N-1:0] pullup_override_val,
  input wire logic [N-1:0] dir_override_en,
  input wire logic [N-1:0] dir_override_val,
  input wire logic [N-1:0] value_override_en,
  input wire logic [N-1:0] value_override_val,
  input wire logic [N-1:0] input_enable_override_en,
  input wire logic [N-1:0] input_enable_override_val,
  // pad and peripheral side
  input wire logic [N-1:0] alt_digital_in,
  input wire logic [N-1:0] analog_pad_link,
  input wire logic [N-1:0] pad_in,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pullup_en
);
  default clocking cb @(posedge aclk); endclocking
  // pins allowed to see input in sleep; int pin always let in since enable is hidden here
  logic [N-1:0] keep_in;
  assign keep_in = (input_enable_override_en & ALT_MASK) | (N'(1) << EXT_INT_PIN);

  a_pullup_rst: assert property (!aresetn |-> pad_pullup_en == '0)
    else $error("pull-up on during reset");
  a_oe_rst: assert property (!aresetn |-> pad_oe == '0)
    else $error("driver on during reset");
  a_pullup_ovr: assert property (disable iff (!aresetn)
    ((pad_pullup_en ^ pullup_override_val) & pullup_override_en & ALT_MASK) == '0)
    else $error("pull-up ignores override");
  a_dir_ovr: assert property (disable iff (!aresetn)
    ((pad_oe ^ dir_override_val) & dir_override_en & ALT_MASK) == '0)
    else $error("driver enable ignores override");
  a_value_ovr: assert property (disable iff (!aresetn)
    ((pad_out ^ value_override_val) & value_override_en & pad_oe & ALT_MASK) == '0)
    else $error("driven level ignores override");
  a_analog_link: assert property (analog_pad_link == pad_in)
    else $error("analog link differs from pad");
  a_ie_ovr: assert property (disable iff (!aresetn)
    ((alt_digital_in ^ (pad_in & input_enable_override_val))
     & input_enable_override_en & ALT_MASK) == '0)
    else $error("input enable ignores override");
  a_input_zero: assert property ((alt_digital_in & ~pad_in) == '0)
    else $error("disabled input not zero");
  a_sleep_clamp: assert property (disable iff (!aresetn)
    power_down |-> (alt_digital_in & ~keep_in) == '0)
    else $error("input not clamped in sleep");
endmodule : pmx_port_checker

bind pmx_port_pin_override_mux pmx_port_checker #(.N(N), .ALT_MASK(ALT_MASK),
  .EXT_INT_PIN(EXT_INT_PIN)) u_pmx_port_checker (.aclk, .aresetn, .power_down,
  .pullup_override_en, .pullup_override_val, .dir_override_en, .dir_override_val,
  .value_override_en, .value_override_val, .input_enable_override_en,
  .input_enable_override_val, .alt_digital_in, .analog_pad_link, .pad_in, .pad_out,
  .pad_oe, .pad_pullup_en);
`default_nettype wire

// ---- bench/pmx_port_pin_override_mux_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// self-checking bench for the pin override mux
module pmx_port_pin_override_mux_bench;
  import pmx_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, power_down = 0;
  logic bready = 1, rready = 1; // always ready for answers
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [5:0] pad_in = 0, alt_digital_in, analog_pad_link, pad_out, pad_oe, pad_pullup_en,
    alt_sync;
  logic [8:0][5:0] want = '0, ovr;
  logic awready, wready, arready, bvalid, rvalid, ext_int_req;
  logic [1:0] bresp, rresp, r;
  int err_total = 0, n_checks = 0;

  pmx_port_pin_override_mux u_pmx_port_pin_override_mux (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .power_down, .pullup_override_en(ovr[0]),
    .pullup_override_val(ovr[1]), .dir_override_en(ovr[2]), .dir_override_val(ovr[3]),
    .value_override_en(ovr[4]), .value_override_val(ovr[5]), .toggle_override_en(ovr[6]),
    .input_enable_override_en(ovr[7]), .input_enable_override_val(ovr[8]), .alt_digital_in,
    .analog_pad_link, .ext_int_req, .pad_in, .pad_out, .pad_oe, .pad_pullup_en);
  pmx_periph_model u_pmx_periph_model (.aclk, .want, .ovr, .alt_in(alt_digital_in), .alt_sync);

  // ==========================================
  // helpers
  initial forever #10 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // write: hold each channel until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask : rd
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ==========================================
  // scenarios
  task automatic t_reset; // overrides pushed in reset
    want[0] <= '1;
    want[1] <= '1;
    want[2] <= '1;
    want[3] <= '1;
    cyc(2);
    chk("oe in reset", 0, pad_oe);
    chk("pull-up in reset", 0, pad_pullup_en);
    want <= '0;
    $display("reset test done");
  endtask : t_reset
  task automatic t_table; // every dir, latch, disable pattern
    logic [2:0] p;
    rd(PMX_OFS_LATCH);
    chk("latch reset", 32'(PMX_RST_LATCH), d);
    for (int k = 0; k < 8; k++) begin
      p = 3'(k);
      wr(PMX_OFS_DIR, {32{p[2]}});
      wr(PMX_OFS_LATCH, {32{p[1]}});
      wr(PMX_OFS_CTRL, {31'h0, p[0]});
      chk("pull-up", (p == 3'b010) ? 6'h3F : 6'h00, pad_pullup_en);
      chk("oe", {6{p[2]}}, pad_oe);
      chk("out", {6{p[2] & p[1]}}, pad_out);
    end
    rd(8'h14);
    chk("unmapped resp", PMX_RESP_SLVERR, r);
    wr(8'h14, 0);
    chk("unmapped wr", PMX_RESP_SLVERR, r);
    $display("table test done");
  endtask : t_table
  task automatic t_override;
    want[0] <= '1;
    want[1] <= 6'h15;
    want[2] <= '1;
    want[3] <= 6'h0F;
    want[4] <= '1;
    want[5] <= 6'h05;
    cyc(2);
    chk("pull-up ovr", 6'h15, pad_pullup_en);
    chk("oe ovr", 6'h0F, pad_oe);
    chk("out ovr", 6'h05, pad_out);
    want <= '0;
    cyc(2);
    chk("oe back", 6'h3F, pad_oe);
    $display("override test done");
  endtask : t_override
  task automatic t_toggle;
    wr(PMX_OFS_LATCH, 32'h0);
    wr(PMX_OFS_PIN, 32'h21);
    rd(PMX_OFS_LATCH);
    chk("pin write toggle", 32'h21, d);
    want[6] <= 6'h03; // exactly one cycle of toggle override
    cyc(1);
    want[6] <= '0;
    cyc(2);
    rd(PMX_OFS_LATCH);
    chk("toggle ovr", 32'h22, d);
    $display("toggle test done");
  endtask : t_toggle
  task automatic t_input;
    pad_in <= 6'h2D;
    cyc(3);
    rd(PMX_OFS_PIN);
    chk("pin sample", 32'h2D, d);
    chk("alt in", 6'h2D, alt_digital_in);
    chk("alt sync", 6'h2D, alt_sync);
    power_down <= 1'b1;
    cyc(2);
    chk("clamped", 0, alt_digital_in);
    chk("analog", 6'h2D, analog_pad_link);
    wr(PMX_OFS_EXTINT, 32'h3);
    want[7] <= 6'h01;
    want[8] <= 6'h01;
    cyc(2);
    chk("kept", 6'h05, alt_digital_in);
    want[7] <= 6'h05;
    want[8] <= 6'h00;
    cyc(2);
    chk("forced off", 0, alt_digital_in);
    want <= '0;
    power_down <= 1'b0;
    $display("input test done");
  endtask : t_input
  task automatic t_resume; // rising sense, disabled, flag cleared, pin high
    wr(PMX_OFS_EXTINT, 32'hE);
    power_down <= 1'b1;
    cyc(3);
    power_down <= 1'b0;
    cyc(4);
    rd(PMX_OFS_EXTINT);
    chk("resume flag", 1, d[PMX_XI_FLAG_BIT]);
    chk("int req", 0, ext_int_req);
    $display("resume test done");
  endtask : t_resume

  // ==========================================
  // main sequence and watchdog
  initial begin
    cyc(2);
    t_reset();
    aresetn <= 1'b1;
    cyc(2);
    t_table();
    t_override();
    t_toggle();
    t_input();
    t_resume();
    end_of_test();
  end
  initial begin
    #50000;
    err_total++;
    end_of_test();
  end
endmodule : pmx_port_pin_override_mux_bench
`default_nettype wire

// ---- include/pmx_pkg.sv ----
package pmx_pkg;

  // ==========================================================
  // bus geometry
  localparam int PMX_ADDR_W = 8;
  localparam int PMX_DATA_W = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PMX_OFS_LATCH = 8'h00;  // output latch bits
  localparam logic [7:0] PMX_OFS_DIR = 8'h04;    // direction bits
  localparam logic [7:0] PMX_OFS_PIN = 8'h08;    // input sample, write one toggles latch
  localparam logic [7:0] PMX_OFS_CTRL = 8'h0C;   // global pull-up disable, sleep state
  localparam logic [7:0] PMX_OFS_EXTINT = 8'h10; // external interrupt control and flag

  // ==========================================================
  // field positions
  localparam int PMX_CTRL_GPD_BIT = 0;   // global_pullup_disable
  localparam int PMX_CTRL_SLEEP_BIT = 1; // power-down seen, read only
  localparam int PMX_XI_EN_BIT = 0;      // external interrupt enable
  localparam int PMX_XI_SENSE_LSB = 1;   // two-bit sense field
  localparam int PMX_XI_FLAG_BIT = 3;    // sticky flag, write one clears

  // ==========================================================
  // reset values
  localparam logic PMX_RST_LATCH = 1'h0;
  localparam logic PMX_RST_DIR = 1'h0;
  localparam logic PMX_RST_GPD = 1'h0;
  localparam logic PMX_RST_XI_EN = 1'h0;
  localparam logic PMX_RST_XI_FLAG = 1'h0;

  // ==========================================================
  // external interrupt sense modes and bus answers
  typedef enum logic [1:0] {
    PMX_SENSE_LOW, PMX_SENSE_ANY, PMX_SENSE_FALL, PMX_SENSE_RISE
  } pmx_sense_t;
  localparam logic [1:0] PMX_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMX_RESP_SLVERR = 2'h2;

endpackage : pmx_pkg

// ---- include/pmx_regs_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// register access between bus slave and port logic
interface pmx_regs_if;
  import pmx_pkg::*;
  logic wr_en;                    // one-cycle write pulse
  logic [PMX_ADDR_W-1:0] wr_addr; // write byte address
  logic [PMX_DATA_W-1:0] wr_data; // write data
  logic [3:0] wr_strb;            // byte lanes
  logic wr_ok;                    // address is mapped
  logic rd_en;                    // one-cycle read pulse
  logic [PMX_ADDR_W-1:0] rd_addr; // read byte address
  logic [PMX_DATA_W-1:0] rd_data; // read data, same cycle
  logic rd_ok;                    // address is mapped

  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : pmx_regs_if

`default_nettype wire

// ---- rtl/pmx_axil_slave.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// axi4-lite slave, one write and one read in flight
module pmx_axil_slave import pmx_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [PMX_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  // write data
  input wire logic [PMX_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  // write response
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [PMX_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  // read data
  output var logic [PMX_DATA_W-1:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  // register side
  pmx_regs_if.bus regs
);

  logic aw_full_reg, aw_full_next;  // address held
  logic [PMX_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic w_full_reg, w_full_next;    // data held
  logic [PMX_DATA_W-1:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [PMX_DATA_W-1:0] rdata_next;
  logic do_wr; // both halves present, no response pending
  logic do_rd; // read address taken this cycle

  assign do_wr = aw_full_reg & w_full_reg & ~bvalid;
  assign do_rd = arvalid & arready;
  assign regs.wr_en = do_wr;
  assign regs.wr_addr = aw_addr_reg;
  assign regs.wr_data = w_data_reg;
  assign regs.wr_strb = w_strb_reg;
  assign regs.rd_en = do_rd;
  assign regs.rd_addr = araddr;

  // next state of both channels
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid;
    bresp_next = bresp;
    rvalid_next = rvalid;
    rdata_next = rdata;
    rresp_next = rresp;
    // address and data accepted in either order
    if (awvalid && awready) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_full_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (bvalid && bready) bvalid_next = 1'b0;
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = regs.wr_ok ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
    end
    if (rvalid && rready) rvalid_next = 1'b0;
    if (do_rd) begin
      rvalid_next = 1'b1;
      rdata_next = regs.rd_data;
      rresp_next = regs.rd_ok ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
    end
    // readies registered so no path runs from valid to ready
    awready_next = ~aw_full_next & ~bvalid_next;
    wready_next = ~w_full_next & ~bvalid_next;
    arready_next = ~rvalid_next;
    if (!aresetn) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      aw_addr_next = '0;
      w_data_next = '0;
      w_strb_next = '0;
      bvalid_next = 1'b0;
      bresp_next = PMX_RESP_OKAY;
      rvalid_next = 1'b0;
      rdata_next = '0;
      rresp_next = PMX_RESP_OKAY;
      awready_next = 1'b0;
      wready_next = 1'b0;
      arready_next = 1'b0;
    end
  end

  // register everything
  always_ff @(posedge aclk) begin
    aw_full_reg <= aw_full_next;
    aw_addr_reg <= aw_addr_next;
    w_full_reg <= w_full_next;
    w_data_reg <= w_data_next;
    w_strb_reg <= w_strb_next;
    awready <= awready_next;
    wready <= wready_next;
    bvalid <= bvalid_next;
    bresp <= bresp_next;
    arready <= arready_next;
    rvalid <= rvalid_next;
    rdata <= rdata_next;
    rresp <= rresp_next;
  end

endmodule : pmx_axil_slave

`default_nettype wire

// ---- rtl/pmx_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// pad input synchroniser: high-transparent latch then flop
module pmx_pin_sync import pmx_pkg::*; #(
  parameter int N = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // data
  input wire logic [N-1:0] din,
  output var logic [N-1:0] dout
);

  logic [N-1:0] lat; // latch stage, only the flop reads it
  logic [N-1:0] samp_next;

  genvar i;
  for (i = 0; i < N; i++) begin : g_bit
    // transparent while clock high, holds while low
    always_latch begin
      if (aclk) lat[i] = din[i];
    end
  end

  // next value of the sampled bits
  always_comb begin
    samp_next = aresetn ? lat : '0;
  end

  // capture at the rising edge
  always_ff @(posedge aclk) begin
    dout <= samp_next;
  end

endmodule : pmx_pin_sync

`default_nettype wire

// ---- rtl/pmx_port_pin_override_mux.sv ----
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Function
// - power-down clamps digital input unless overridden
// - no clamp on enabled external interrupt pin
// - disabled edge interrupt, pin high: flag on resume
// - pull-ups off while reset is active
// - pull-up on when dir,latch,disable equal 010
// - pull-up override enable selects override value
// - direction override selects output driver enable
// - driven level from value override or latch
// - toggle override inverts the output latch
// - input-enable override decides digital input enable
// - alternate input taken before synchroniser
// - analog link wired straight to pad
// - strobes per port, overrides per pin
// - writing one to input bit toggles latch
// - input sampled by latch then flop
// - direction one drives; reset tri-states all pins
module pmx_port_pin_override_mux import pmx_pkg::*; #(
  parameter int N = 6,                         // pins in the port
  parameter logic [N-1:0] ALT_MASK = '1,       // pins with alternate function
  parameter int EXT_INT_PIN = 2                // pin carrying the external interrupt
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,

  // axi4-lite write address
  input wire logic [PMX_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,

  // axi4-lite write data
  input wire logic [PMX_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,

  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,

  // axi4-lite read address
  input wire logic [PMX_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,

  // axi4-lite read data
  output logic [PMX_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,

  // sleep controller
  input wire logic power_down,

  // per-pin overrides from peripherals
  input wire logic [N-1:0] pullup_override_en,
  input wire logic [N-1:0] pullup_override_val,
  input wire logic [N-1:0] dir_override_en,
  input wire logic [N-1:0] dir_override_val,
  input wire logic [N-1:0] value_override_en,
  input wire logic [N-1:0] value_override_val,
  input wire logic [N-1:0] toggle_override_en,
  input wire logic [N-1:0] input_enable_override_en,
  input wire logic [N-1:0] input_enable_override_val,

  // toward peripherals
  output logic [N-1:0] alt_digital_in,
  output logic [N-1:0] analog_pad_link,
  output logic ext_int_req,

  // pad
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pullup_en
);

  // ==========================================================
  // register access
  pmx_regs_if regs_if ();

  pmx_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(regs_if.bus)
  );

  // port-wide strobes, shared by every pin of the port
  logic lane0;                   // low byte lane written
  logic latch_write_strobe;      // output latch write
  logic toggle_write_strobe;     // input register write, toggles latch
  logic direction_write_strobe;  // direction write
  logic ctrl_write_strobe;       // control write
  logic extint_write_strobe;     // external interrupt write
  logic latch_read_strobe;
  logic pin_read_strobe;
  logic direction_read_strobe;
  logic ctrl_read_strobe;
  logic extint_read_strobe;
  logic [N-1:0] wr_bits;         // low write data bits

  assign lane0 = regs_if.wr_en & regs_if.wr_strb[0];
  assign wr_bits = regs_if.wr_data[N-1:0];

  assign latch_write_strobe = lane0 & (regs_if.wr_addr == PMX_OFS_LATCH);
  assign toggle_write_strobe = lane0 & (regs_if.wr_addr == PMX_OFS_PIN);
  assign direction_write_strobe = lane0 & (regs_if.wr_addr == PMX_OFS_DIR);
  assign ctrl_write_strobe = lane0 & (regs_if.wr_addr == PMX_OFS_CTRL);
  assign extint_write_strobe = lane0 & (regs_if.wr_addr == PMX_OFS_EXTINT);
  assign latch_read_strobe = regs_if.rd_en & (regs_if.rd_addr == PMX_OFS_LATCH);
  assign pin_read_strobe = regs_if.rd_en & (regs_if.rd_addr == PMX_OFS_PIN);
  assign direction_read_strobe = regs_if.rd_en & (regs_if.rd_addr == PMX_OFS_DIR);
  assign ctrl_read_strobe = regs_if.rd_en & (regs_if.rd_addr == PMX_OFS_CTRL);
  assign extint_read_strobe = regs_if.rd_en & (regs_if.rd_addr == PMX_OFS_EXTINT);

  // ==========================================================
  // state
  logic [N-1:0] latch_reg, latch_next;      // pin_output_latch_bit per pin
  logic [N-1:0] dir_reg, dir_next;          // pin_direction_bit per pin
  logic gpd_reg, gpd_next;                  // global_pullup_disable
  logic xen_reg, xen_next;                  // external interrupt enable
  pmx_sense_t xsense_reg, xsense_next;      // external interrupt sense
  logic xflag_reg, xflag_next;              // sticky external interrupt flag
  logic samp_prev_reg, samp_prev_next;      // previous sample of interrupt pin
  logic pd_prev_reg, pd_prev_next;          // power_down one cycle ago
  logic xreq_next;
  logic [N-1:0] pin_input_sample;           // synchronised pad level after the input clamp

  // masked overrides; pins without alternate function see none
  logic [N-1:0] m_pu, m_dir, m_val, m_tog, m_ie;
  assign m_pu = pullup_override_en & ALT_MASK;
  assign m_dir = dir_override_en & ALT_MASK;
  assign m_val = value_override_en & ALT_MASK;
  assign m_tog = toggle_override_en & ALT_MASK;
  assign m_ie = input_enable_override_en & ALT_MASK;

  // ==========================================================
  // per-pin pad logic
  logic [N-1:0] in_en;     // digital input enable
  logic [N-1:0] in_gated;  // schmitt output after clamp
  logic [N-1:0] drive_en;  // output driver enable before reset gate

  genvar i;
  for (i = 0; i < N; i++) begin : g_pin
    localparam bit IS_XPIN = (i == EXT_INT_PIN);
    // sleep clamp, lifted for an enabled interrupt pin
    assign in_en[i] = m_ie[i] ? input_enable_override_val[i]
                    : ~(power_down & ~(IS_XPIN & xen_reg));
    // clamp ahead of the trigger: disabled input reads zero
    assign in_gated[i] = pad_in[i] & in_en[i];
    assign drive_en[i] = m_dir[i] ? dir_override_val[i] : dir_reg[i];
    // reset acts without the clock so pins float even if it stalls
    assign pad_oe[i] = aresetn & drive_en[i];
    assign pad_out[i] = pad_oe[i] & (m_val[i] ? value_override_val[i] : latch_reg[i]);
    assign pad_pullup_en[i] = aresetn
      & (m_pu[i] ? pullup_override_val[i]
         : ({dir_reg[i], latch_reg[i], gpd_reg} == 3'h2));
  end

  // raw trigger output to peripherals, they synchronise it
  assign alt_digital_in = in_gated;
  // analog path is the pad itself, no gating
  assign analog_pad_link = pad_in;

  // ==========================================================
  // synchroniser feeding the input register
  pmx_pin_sync #(
    .N(N)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(in_gated),
    .dout(pin_input_sample)
  );

  // ==========================================================
  // port registers and external interrupt
  logic x_samp;    // synchronised interrupt pin
  logic x_edge;    // selected sense matched
  logic x_resume;  // wake-up with clamp released on a high pin
  logic x_clear;   // software write of one to the flag

  assign x_samp = pin_input_sample[EXT_INT_PIN];

  // sense decode
  always_comb begin
    unique case (xsense_reg)
      PMX_SENSE_LOW: x_edge = ~x_samp;
      PMX_SENSE_ANY: x_edge = x_samp ^ samp_prev_reg;
      PMX_SENSE_FALL: x_edge = samp_prev_reg & ~x_samp;
      PMX_SENSE_RISE: x_edge = ~samp_prev_reg & x_samp;
    endcase
  end

  // the clamp released on a high pin looks like a change
  assign x_resume = pd_prev_reg & ~power_down & ~xen_reg
                  & (xsense_reg != PMX_SENSE_LOW) & pad_in[EXT_INT_PIN];
  assign x_clear = extint_write_strobe & regs_if.wr_data[PMX_XI_FLAG_BIT];

  // next values of all port state
  always_comb begin
    latch_next = latch_reg;
    dir_next = dir_reg;
    gpd_next = gpd_reg;
    xen_next = xen_reg;
    xsense_next = xsense_reg;
    if (latch_write_strobe) latch_next = wr_bits;
    if (toggle_write_strobe) latch_next = latch_next ^ wr_bits;
    // held override toggles every clock
    latch_next = latch_next ^ m_tog;
    if (direction_write_strobe) dir_next = wr_bits;
    if (ctrl_write_strobe) gpd_next = regs_if.wr_data[PMX_CTRL_GPD_BIT];
    if (extint_write_strobe) begin
      xen_next = regs_if.wr_data[PMX_XI_EN_BIT];
      xsense_next = pmx_sense_t'(regs_if.wr_data[PMX_XI_SENSE_LSB +: 2]);
    end
    // a set in the clearing cycle wins
    xflag_next = (xflag_reg & ~x_clear) | (xen_reg & x_edge) | x_resume;
    samp_prev_next = x_samp;
    pd_prev_next = power_down;
    xreq_next = xflag_next & xen_next;
    if (!aresetn) begin
      latch_next = {N{PMX_RST_LATCH}};
      dir_next = {N{PMX_RST_DIR}};
      gpd_next = PMX_RST_GPD;
      xen_next = PMX_RST_XI_EN;
      xsense_next = PMX_SENSE_LOW;
      xflag_next = PMX_RST_XI_FLAG;
      samp_prev_next = 1'b0;
      pd_prev_next = 1'b0;
      xreq_next = 1'b0;
    end
  end

  // register port state
  always_ff @(posedge aclk) begin
    latch_reg <= latch_next;
    dir_reg <= dir_next;
    gpd_reg <= gpd_next;
    xen_reg <= xen_next;
    xsense_reg <= xsense_next;
    xflag_reg <= xflag_next;
    samp_prev_reg <= samp_prev_next;
    pd_prev_reg <= pd_prev_next;
    ext_int_req <= xreq_next;
  end

  // ==========================================================
  // read mux and address map
  always_comb begin
    regs_if.rd_data = '0;
    regs_if.rd_ok = 1'b1;
    if (latch_read_strobe) regs_if.rd_data[N-1:0] = latch_reg;
    else if (direction_read_strobe) regs_if.rd_data[N-1:0] = dir_reg;
    else if (pin_read_strobe) regs_if.rd_data[N-1:0] = pin_input_sample;
    else if (ctrl_read_strobe) begin
      regs_if.rd_data[PMX_CTRL_GPD_BIT] = gpd_reg;
      regs_if.rd_data[PMX_CTRL_SLEEP_BIT] = pd_prev_reg;
    end else if (extint_read_strobe) begin
      regs_if.rd_data[PMX_XI_EN_BIT] = xen_reg;
      regs_if.rd_data[PMX_XI_SENSE_LSB +: 2] = xsense_reg;
      regs_if.rd_data[PMX_XI_FLAG_BIT] = xflag_reg;
    end else regs_if.rd_ok = 1'b0;
  end

  // unmapped writes are dropped and answered with an error
  assign regs_if.wr_ok = (regs_if.wr_addr == PMX_OFS_LATCH)
                       | (regs_if.wr_addr == PMX_OFS_DIR)
                       | (regs_if.wr_addr == PMX_OFS_PIN)
                       | (regs_if.wr_addr == PMX_OFS_CTRL)
                       | (regs_if.wr_addr == PMX_OFS_EXTINT);

endmodule : pmx_port_pin_override_mux

`default_nettype wire
